// ==== src/gcps_pkg.sv ====
// package of constants and types for the global clock and pin select block
package gcps_pkg;

   // ************************************************************
   // bus and register map
   // ************************************************************
   localparam int          APB_ADDR_W      = 12;
   localparam int          APB_DATA_W      = 32;
   localparam int          REG_IDX_W       = 10;
   // register indexes; byte address is four times the index
   localparam logic [9:0]  IDX_FRAMER_CTRL = 10'h0f1;
   localparam logic [9:0]  IDX_TX_SYNC_SEL = 10'h0f2;
   localparam logic [9:0]  IDX_CLK_REF_SEL = 10'h0f3;
   localparam logic [9:0]  IDX_SYSCLK_SEL  = 10'h0f4;
   localparam logic [9:0]  IDX_STATUS      = 10'h100;

   // ************************************************************
   // reset values and writable masks
   // ************************************************************
   localparam logic [7:0]  REG_RESET       = 8'h00;
   localparam logic [7:0]  FC_MASK         = 8'h37;
   localparam logic [7:0]  TS_MASK         = 8'h03;
   localparam logic [7:0]  CR_MASK         = 8'hff;
   localparam logic [7:0]  SC_MASK         = 8'h60;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int          FC_RX_CHAN_BIT  = 0;
   localparam int          FC_TX_CHAN_BIT  = 1;
   localparam int          FC_RX_SYNC_BIT  = 2;
   localparam int          FC_BP_OUT_LSB   = 4;
   localparam int          TS_PIN_BIT      = 0;
   localparam int          TS_DIR_BIT      = 1;
   localparam int          CR_MPS_LSB      = 0;
   localparam int          CR_FAMILY_BIT   = 2;
   localparam int          CR_BFREQ_BIT    = 3;
   localparam int          CR_REF_LSB      = 4;
   localparam int          SC_TX_BIT       = 5;
   localparam int          SC_RX_BIT       = 6;
   localparam int          ST_REF_OUT_BIT  = 0;
   localparam int          ST_REF_RSV_BIT  = 1;
   localparam int          ST_REF_LINE_BIT = 2;
   localparam int          ST_KHZ_LSB      = 16;

   // ************************************************************
   // backplane reference codes and frequencies
   // ************************************************************
   localparam logic [3:0]  REF_PORT4       = 4'h3;
   localparam logic [3:0]  REF_MCLK        = 4'h8;
   localparam logic [3:0]  REF_EXT         = 4'h9;
   localparam logic [15:0] KHZ_FAMILY_E1   = 16'h0800; // 2048 kHz
   localparam logic [15:0] KHZ_FAMILY_T1   = 16'h0608; // 1544 kHz

   typedef enum logic [1:0] {
      SRC_LINE = 2'b00,
      SRC_MCLK = 2'b01,
      SRC_EXT  = 2'b10,
      SRC_NONE = 2'b11
   } gcps_ref_src_t;

   typedef enum logic {
      APB_IDLE = 1'b0,
      APB_DONE = 1'b1
   } gcps_apb_st_t;

   // ************************************************************
   // carriers
   // ************************************************************
   typedef struct packed {
      logic rx_sync_kind_sel;
      logic tx_chan_pin_sel;
      logic rx_chan_pin_sel;
      logic sys_sync_direction;
      logic tx_sync_pin_sel;
      logic rx_sysclk_source;
      logic tx_sysclk_source;
   } gcps_cfg_t;

   typedef struct packed {
      logic rx_frame_sync;
      logic rx_multiframe_sync;
      logic tx_chan_block;
      logic tx_chan_clock;
      logic rx_chan_block;
      logic rx_chan_clock;
      logic tx_frame_sync_out;
      logic tx_io_control;
      logic tx_system_sync_out;
   } gcps_port_in_t;

   typedef struct packed {
      logic rx_sync_pin;
      logic tx_chan_pin;
      logic rx_chan_pin;
      logic tx_frame_sync_in;
      logic tx_system_sync_in;
      logic rx_system_clock;
      logic tx_system_clock;
   } gcps_port_out_t;

endpackage

// ==== src/gcps_port_mux.sv ====
// per-port shared pin multiplexer
`timescale 1ns/100ps
`default_nettype none
module gcps_port_mux (
   input  wire logic                     ref_clk,
   input  wire logic                     resetn,
   input  wire gcps_pkg::gcps_cfg_t      cfg,
   input  wire gcps_pkg::gcps_port_in_t  port_in,
   input  wire logic                     bp_clk_sync,
   input  wire logic                     tx_sync_pin_in,
   input  wire logic                     rx_sysclk_pin,
   input  wire logic                     tx_sysclk_pin,
   output logic                          tx_sync_pin_out,
   output logic                          tx_sync_pin_oe_n,
   output gcps_pkg::gcps_port_out_t      port_out
);
   import gcps_pkg::*;

   logic [1:0] sync_pin_reg;
   logic [1:0] rx_clk_reg;
   logic [1:0] tx_clk_reg;
   logic       drive_next;

   // two-stage synchronisers for pins
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         sync_pin_reg <= 2'h0;
         rx_clk_reg   <= 2'h0;
         tx_clk_reg   <= 2'h0;
      end else begin
         sync_pin_reg <= {sync_pin_reg[0], tx_sync_pin_in};
         rx_clk_reg   <= {rx_clk_reg[0], rx_sysclk_pin};
         tx_clk_reg   <= {tx_clk_reg[0], tx_sysclk_pin};
      end
   end

   // direction of the shared transmit sync pin
   always_comb begin
      if (cfg.tx_sync_pin_sel) begin
         drive_next = cfg.sys_sync_direction;
      end else begin
         drive_next = port_in.tx_io_control;
      end
   end

   // registered pin and function selection
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         port_out         <= '0;
         tx_sync_pin_out  <= 1'b0;
         tx_sync_pin_oe_n <= 1'b1;
      end else begin
         port_out.rx_sync_pin <= cfg.rx_sync_kind_sel ? port_in.rx_multiframe_sync
                                                      : port_in.rx_frame_sync;
         port_out.tx_chan_pin <= cfg.tx_chan_pin_sel ? port_in.tx_chan_clock
                                                     : port_in.tx_chan_block;
         port_out.rx_chan_pin <= cfg.rx_chan_pin_sel ? port_in.rx_chan_clock
                                                     : port_in.rx_chan_block;
         tx_sync_pin_oe_n     <= ~drive_next;
         tx_sync_pin_out      <= cfg.tx_sync_pin_sel ? port_in.tx_system_sync_out
                                                     : port_in.tx_frame_sync_out;
         // received sync goes only to the function routed onto the pin
         port_out.tx_frame_sync_in  <= ~cfg.tx_sync_pin_sel & ~drive_next
                                       & sync_pin_reg[1];
         port_out.tx_system_sync_in <= cfg.tx_sync_pin_sel & ~drive_next
                                       & sync_pin_reg[1];
         port_out.rx_system_clock   <= cfg.rx_sysclk_source ? bp_clk_sync
                                                            : rx_clk_reg[1];
         port_out.tx_system_clock   <= cfg.tx_sysclk_source ? bp_clk_sync
                                                            : tx_clk_reg[1];
      end
   end

endmodule
`default_nettype wire

// ==== src/gcps_top.sv ====
// global clock and shared pin select block with APB register access
// ************************************************************
// How it works
// - bit 2 picks frame or multiframe receive sync
// - bit 1 picks transmit channel block or clock
// - bit 0 picks receive channel block or clock
// - direction bit makes system sync input or output
// - pin select routes frame or system sync
// - frame sync direction follows per-port I/O control
// - reference field picks line, master, or external source
// - reference pin output for master, input for external
// - backplane frequency bit: 2.048 or 1.544 MHz
// - family bit: 2.048 or 1.544 MHz master
// - period field scales master by 1,2,4,8
// - receive system clocks from pins or backplane
// - transmit system clocks from pins or backplane
// - backplane output select 2.048 to 16.384 MHz
// ************************************************************
//
// Design decision made here: the APB register port.
`timescale 1ns/100ps
`default_nettype none
module gcps_top #(
   parameter int PORTS = 4
) (
   input  wire logic                                ref_clk,
   input  wire logic                                resetn,
   // apb slave
   input  wire logic                                psel,
   input  wire logic                                penable,
   input  wire logic                                pwrite,
   input  wire logic [gcps_pkg::APB_ADDR_W-1:0]     paddr,
   input  wire logic [gcps_pkg::APB_DATA_W-1:0]     pwdata,
   output logic      [gcps_pkg::APB_DATA_W-1:0]     prdata,
   output logic                                     pready,
   output logic                                     pslverr,
   // per-port framer side signals and results
   input  wire gcps_pkg::gcps_port_in_t [PORTS-1:0] port_in,
   output gcps_pkg::gcps_port_out_t     [PORTS-1:0] port_out,
   // shared transmit sync pins, output enable low while driving
   input  wire logic                    [PORTS-1:0] tx_sync_pin_in,
   output logic                         [PORTS-1:0] tx_sync_pin_out,
   output logic                         [PORTS-1:0] tx_sync_pin_oe_n,
   // per-port system clock pins
   input  wire logic                    [PORTS-1:0] rx_system_clock_pin,
   input  wire logic                    [PORTS-1:0] tx_system_clock_pin,
   // backplane clock from the backplane generator
   input  wire logic                                backplane_clock,
   // master-clock derived reference and reference pin
   input  wire logic                                mclk_ref_clk,
   input  wire logic                                reference_clock_pin_in,
   output logic                                     reference_clock_pin_out,
   output logic                                     reference_clock_pin_oe_n,
   // controls for the backplane and master clock circuits
   output gcps_pkg::gcps_ref_src_t                  backplane_ref_src,
   output logic      [1:0]                          backplane_ref_port,
   output logic                                     backplane_ref_clk,
   output logic                                     backplane_freq_sel,
   output logic      [1:0]                          backplane_out_sel,
   output logic                                     master_family_sel,
   output logic      [1:0]                          master_period_sel
);
   import gcps_pkg::*;

   // ************************************************************
   // declarations
   // ************************************************************
   logic [7:0]          framer_ctrl_reg;
   logic [7:0]          tx_sync_select_reg;
   logic [7:0]          clock_reference_select_reg;
   logic [7:0]          system_clock_source_select_reg;
   gcps_apb_st_t        apb_st_reg;
   gcps_apb_st_t        apb_st_next;
   logic [1:0]          bp_clk_reg;
   logic [1:0]          ext_ref_reg;
   logic [REG_IDX_W-1:0] reg_idx;
   logic                wr_take;
   logic                idx_hit;
   logic [APB_DATA_W-1:0] rd_next;
   logic [3:0]          ref_code;
   gcps_ref_src_t       ref_src_next;
   logic [15:0]         master_khz;
   logic [APB_DATA_W-1:0] status_word;
   gcps_cfg_t           cfg;

   // ************************************************************
   // apb access handshake
   // ************************************************************
   assign reg_idx = paddr[APB_ADDR_W-1:2];
   // a write lands only on the edge that sees pready high
   assign wr_take = psel & penable & pwrite & (apb_st_reg == APB_DONE);

   // one wait state, then a single-cycle pready
   always_comb begin
      case (apb_st_reg)
         APB_IDLE: begin
            if (psel && penable) begin
               apb_st_next = APB_DONE;
            end else begin
               apb_st_next = APB_IDLE;
            end
         end
         APB_DONE: begin
            apb_st_next = APB_IDLE;
         end
         default: begin
            apb_st_next = APB_IDLE;
         end
      endcase
   end

   // state and pready
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         apb_st_reg <= APB_IDLE;
         pready     <= 1'b0;
      end else begin
         apb_st_reg <= apb_st_next;
         pready     <= (apb_st_next == APB_DONE);
      end
   end

   // address decode
   always_comb begin
      case (reg_idx)
         IDX_FRAMER_CTRL, IDX_TX_SYNC_SEL, IDX_CLK_REF_SEL,
         IDX_SYSCLK_SEL, IDX_STATUS: begin
            idx_hit = 1'b1;
         end
         default: begin
            idx_hit = 1'b0;
         end
      endcase
   end

   // ************************************************************
   // control registers
   // ************************************************************
   // unused bits stay zero through the masks
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         framer_ctrl_reg                <= REG_RESET;
         tx_sync_select_reg             <= REG_RESET;
         clock_reference_select_reg     <= REG_RESET;
         system_clock_source_select_reg <= REG_RESET;
      end else if (wr_take) begin
         case (reg_idx)
            IDX_FRAMER_CTRL: begin
               framer_ctrl_reg <= pwdata[7:0] & FC_MASK;
            end
            IDX_TX_SYNC_SEL: begin
               tx_sync_select_reg <= pwdata[7:0] & TS_MASK;
            end
            IDX_CLK_REF_SEL: begin
               clock_reference_select_reg <= pwdata[7:0] & CR_MASK;
            end
            IDX_SYSCLK_SEL: begin
               system_clock_source_select_reg <= pwdata[7:0] & SC_MASK;
            end
            default: begin
               framer_ctrl_reg <= framer_ctrl_reg;
            end
         endcase
      end
   end

   // ************************************************************
   // configuration fan-out to the ports
   // ************************************************************
   assign cfg.rx_sync_kind_sel   = framer_ctrl_reg[FC_RX_SYNC_BIT];
   assign cfg.tx_chan_pin_sel    = framer_ctrl_reg[FC_TX_CHAN_BIT];
   assign cfg.rx_chan_pin_sel    = framer_ctrl_reg[FC_RX_CHAN_BIT];
   assign cfg.sys_sync_direction = tx_sync_select_reg[TS_DIR_BIT];
   assign cfg.tx_sync_pin_sel    = tx_sync_select_reg[TS_PIN_BIT];
   assign cfg.rx_sysclk_source   = system_clock_source_select_reg[SC_RX_BIT];
   assign cfg.tx_sysclk_source   = system_clock_source_select_reg[SC_TX_BIT];

   // ************************************************************
   // reference source decode
   // ************************************************************
   assign ref_code = clock_reference_select_reg[CR_REF_LSB +: 4];

   // line ports, master derivative, external pin, or reserved
   always_comb begin
      if (ref_code <= REF_PORT4) begin
         ref_src_next = SRC_LINE;
      end else if (ref_code == REF_MCLK) begin
         ref_src_next = SRC_MCLK;
      end else if (ref_code == REF_EXT) begin
         ref_src_next = SRC_EXT;
      end else begin
         ref_src_next = SRC_NONE;
      end
   end

   // master clock frequency in kHz: family shifted by period
   always_comb begin
      if (clock_reference_select_reg[CR_FAMILY_BIT]) begin
         master_khz = KHZ_FAMILY_T1 << clock_reference_select_reg[CR_MPS_LSB +: 2];
      end else begin
         master_khz = KHZ_FAMILY_E1 << clock_reference_select_reg[CR_MPS_LSB +: 2];
      end
   end

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         bp_clk_reg  <= 2'h0;
         ext_ref_reg <= 2'h0;
      end else begin
         bp_clk_reg  <= {bp_clk_reg[0], backplane_clock};
         ext_ref_reg <= {ext_ref_reg[0], reference_clock_pin_in};
      end
   end

   // ************************************************************
   // clock control outputs
   // ************************************************************
   // reference pin drives only for the master derivative
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         reference_clock_pin_out  <= 1'b0;
         reference_clock_pin_oe_n <= 1'b1;
         backplane_ref_clk        <= 1'b0;
      end else begin
         reference_clock_pin_out  <= mclk_ref_clk & (ref_src_next == SRC_MCLK);
         reference_clock_pin_oe_n <= (ref_src_next != SRC_MCLK);
         case (ref_src_next)
            SRC_MCLK: begin
               backplane_ref_clk <= mclk_ref_clk;
            end
            SRC_EXT: begin
               backplane_ref_clk <= ext_ref_reg[1];
            end
            default: begin
               backplane_ref_clk <= 1'b0;
            end
         endcase
      end
   end

   // selections handed to the backplane and master clock circuits
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         backplane_ref_src  <= SRC_LINE;
         backplane_ref_port <= 2'h0;
         backplane_freq_sel <= 1'b0;
         backplane_out_sel  <= 2'h0;
         master_family_sel  <= 1'b0;
         master_period_sel  <= 2'h0;
      end else begin
         backplane_ref_src  <= ref_src_next;
         backplane_ref_port <= ref_code[1:0];
         backplane_freq_sel <= clock_reference_select_reg[CR_BFREQ_BIT];
         backplane_out_sel  <= framer_ctrl_reg[FC_BP_OUT_LSB +: 2];
         master_family_sel  <= clock_reference_select_reg[CR_FAMILY_BIT];
         master_period_sel  <= clock_reference_select_reg[CR_MPS_LSB +: 2];
      end
   end

   // ************************************************************
   // read path
   // ************************************************************
   // status word reflects live clock selection state
   always_comb begin
      status_word                        = '0;
      status_word[ST_REF_OUT_BIT]        = ~reference_clock_pin_oe_n;
      status_word[ST_REF_RSV_BIT]        = (backplane_ref_src == SRC_NONE);
      status_word[ST_REF_LINE_BIT]       = (backplane_ref_src == SRC_LINE);
      status_word[ST_KHZ_LSB +: 16]      = master_khz;
   end

   // read mux, narrow registers in the low bits
   always_comb begin
      rd_next = '0;
      case (reg_idx)
         IDX_FRAMER_CTRL: begin
            rd_next[7:0] = framer_ctrl_reg;
         end
         IDX_TX_SYNC_SEL: begin
            rd_next[7:0] = tx_sync_select_reg;
         end
         IDX_CLK_REF_SEL: begin
            rd_next[7:0] = clock_reference_select_reg;
         end
         IDX_SYSCLK_SEL: begin
            rd_next[7:0] = system_clock_source_select_reg;
         end
         IDX_STATUS: begin
            rd_next = status_word;
         end
         default: begin
            rd_next = '0;
         end
      endcase
   end

   // read data and error valid with pready
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         prdata  <= '0;
         pslverr <= 1'b0;
      end else if (apb_st_next == APB_DONE) begin
         prdata  <= pwrite ? '0 : rd_next;
         pslverr <= ~idx_hit | (pwrite & (reg_idx == IDX_STATUS));
      end else begin
         prdata  <= '0;
         pslverr <= 1'b0;
      end
   end

   // ************************************************************
   // per-port shared pins
   // ************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < PORTS; gi++) begin : g_port
         gcps_port_mux u_port (
            .ref_clk          (ref_clk),
            .resetn           (resetn),
            .cfg              (cfg),
            .port_in          (port_in[gi]),
            .bp_clk_sync      (bp_clk_reg[1]),
            .tx_sync_pin_in   (tx_sync_pin_in[gi]),
            .rx_sysclk_pin    (rx_system_clock_pin[gi]),
            .tx_sysclk_pin    (tx_system_clock_pin[gi]),
            .tx_sync_pin_out  (tx_sync_pin_out[gi]),
            .tx_sync_pin_oe_n (tx_sync_pin_oe_n[gi]),
            .port_out         (port_out[gi])
         );
      end
   endgenerate

endmodule
`default_nettype wire

// ==== dv/gcps_top_props.sv ====
// checker for the clock and pin select block
`timescale 1ns/100ps
`default_nettype none
module gcps_top_props
   import gcps_pkg::*;
#(
   parameter int PORTS = 4
) (
   input wire logic                     ref_clk,
   input wire logic                     resetn,
   input wire logic                     psel,
   input wire logic                     penable,
   input wire logic                     pwrite,
   input wire logic [APB_ADDR_W-1:0]    paddr,
   input wire logic [APB_DATA_W-1:0]    pwdata,
   input wire logic                     pready,
   input wire logic                     pslverr,
   input wire gcps_port_in_t [PORTS-1:0]  port_in,
   input wire gcps_port_out_t [PORTS-1:0] port_out,
   input wire logic [PORTS-1:0]         tx_sync_pin_oe_n,
   input wire logic                     reference_clock_pin_oe_n,
   input wire gcps_ref_src_t            backplane_ref_src,
   input wire logic                     backplane_freq_sel,
   input wire logic                     master_family_sel,
   input wire logic [1:0]               master_period_sel
);
   // *****
   // register shadows and settle age
   // *****
   logic [7:0] fc_q, ts_q, cr_q;
   logic [2:0] age;
   wire        wr = psel && penable && pwrite && pready;
   wire [3:0]  rc = cr_q[7:4];
   // mirror writes, count cycles since last one
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         {fc_q, ts_q, cr_q, age} <= '0;
      end else begin
         age <= wr ? 3'h0 : age + {2'h0, age != 3'h7};
         if (wr && paddr[11:2] == IDX_FRAMER_CTRL) fc_q <= pwdata[7:0] & FC_MASK;
         if (wr && paddr[11:2] == IDX_TX_SYNC_SEL) ts_q <= pwdata[7:0] & TS_MASK;
         if (wr && paddr[11:2] == IDX_CLK_REF_SEL) cr_q <= pwdata[7:0];
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   sequence s_access; $rose(psel && penable); endsequence
   sequence s_answer; !pready ##1 pready; endsequence
   a_pready_wait: assert property (s_access |-> s_answer)
      else $error("pready late");
   a_pready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_err_with_ready: assert property (pslverr |-> pready && psel && penable)
      else $error("pslverr outside an answer");
   a_rx_sync_sel: assert property (age > 3'h3 |-> port_out[0].rx_sync_pin ==
      (fc_q[2] ? $past(port_in[0].rx_multiframe_sync) : $past(port_in[0].rx_frame_sync)))
      else $error("receive sync pin wrong");
   a_chan_pin_sel: assert property (age > 3'h3 |->
      port_out[0].tx_chan_pin == $past(fc_q[1] ? port_in[0].tx_chan_clock : port_in[0].tx_chan_block)
      && port_out[0].rx_chan_pin == $past(fc_q[0] ? port_in[0].rx_chan_clock
      : port_in[0].rx_chan_block)) else $error("channel pin wrong");
   a_sync_pin_dir: assert property (age > 3'h3 |-> tx_sync_pin_oe_n[0] ==
      (ts_q[0] ? !ts_q[1] : !$past(port_in[0].tx_io_control))) else $error("sync pin dir wrong");
   a_ref_pin_dir: assert property (age > 3'h3 |-> reference_clock_pin_oe_n == (rc != REF_MCLK))
      else $error("reference pin dir wrong");
   a_ref_src_code: assert property (age > 3'h3 |-> backplane_ref_src == ((rc <= REF_PORT4) ?
      SRC_LINE : (rc == REF_MCLK) ? SRC_MCLK : (rc == REF_EXT) ? SRC_EXT : SRC_NONE))
      else $error("reference source wrong");
   a_master_fields: assert property (age > 3'h3 |->
      {backplane_freq_sel, master_family_sel, master_period_sel} == cr_q[3:0])
      else $error("clock fields wrong");
endmodule
bind gcps_top gcps_top_props #(.PORTS(PORTS)) u_props (.*);
`default_nettype wire

// ==== dv/test_gcps_top.sv ====
// self-checking bench for the clock and pin select block
`timescale 1ns/100ps
`default_nettype none
module test_gcps_top;
   import gcps_pkg::*;
   logic                   ref_clk = 1'b0, resetn = 1'b0;
   logic                   psel = 1'b0, penable = 1'b0, pwrite = 1'b0, backplane_clock = 1'b0;
   logic [11:0]            paddr = 12'h000;
   logic [31:0]            pwdata = 32'h0, prdata, rd_q;
   logic                   pready, pslverr, err_q;
   logic [35:0]            pi_v = '0;
   logic [5:0]             pv = '0;
   logic [3:0]             rx_system_clock_pin = 4'h0, tx_system_clock_pin = 4'h0;
   wire gcps_port_in_t [3:0] port_in = pi_v;
   wire [3:0]              tx_sync_pin_in = pv[3:0];
   wire                    mclk_ref_clk = pv[4];
   wire                    reference_clock_pin_in = pv[5];
   gcps_port_out_t [3:0]   port_out;
   logic [3:0]             tx_sync_pin_out, tx_sync_pin_oe_n;
   logic                   reference_clock_pin_out, reference_clock_pin_oe_n, backplane_ref_clk;
   gcps_ref_src_t          backplane_ref_src;
   logic [1:0]             backplane_ref_port, backplane_out_sel, master_period_sel;
   logic                   backplane_freq_sel, master_family_sel;
   int                     fails = 0, checks = 0;
   gcps_top #(.PORTS(4)) u_dut (.*);
   // clock and moving pin patterns
   initial forever #12.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      pi_v <= {pi_v[34:0], ~pi_v[35]};
      pv <= {pv[4:0], ~pv[5]};
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one apb transfer, held until pready
   task automatic apb(input logic w, input logic [9:0] ix, input logic [7:0] d);
      @(posedge ref_clk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, ix, 2'b00, 24'h0, d};
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      {rd_q, err_q} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
   endtask
   task automatic t_regs;
      logic [9:0] ix [4] = '{IDX_FRAMER_CTRL, IDX_TX_SYNC_SEL, IDX_CLK_REF_SEL, IDX_SYSCLK_SEL};
      logic [7:0] mk [4] = '{FC_MASK, TS_MASK, CR_MASK, SC_MASK};
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, ix[i], 8'h00);
         chk(rd_q, 32'h0);
         apb(1'b1, ix[i], 8'hff);
         apb(1'b0, ix[i], 8'h00);
         chk(rd_q, {24'h0, mk[i]});
      end
      apb(1'b0, 10'h0f5, 8'h00);
      chk(rd_q, 32'h0);
      chk({31'h0, err_q}, 32'h1);
      $display("t_regs done");
   endtask
   task automatic t_pins;
      for (int k = 0; k < 32; k++) begin
         apb(1'b1, IDX_FRAMER_CTRL, {5'h00, k[2:0]});
         apb(1'b1, IDX_TX_SYNC_SEL, {6'h00, k[4:3]});
         repeat (8) @(posedge ref_clk);
         for (int i = 0; i < 4; i++) chk(tx_sync_pin_out[i], pi_v[i*9+3-2*k[3]]);
      end
      $display("t_pins done");
   endtask
   task automatic t_ref;
      gcps_ref_src_t e;
      for (int c = 0; c < 16; c++) begin
         e = (c < 4) ? SRC_LINE : (c == 8) ? SRC_MCLK : (c == 9) ? SRC_EXT : SRC_NONE;
         apb(1'b1, IDX_CLK_REF_SEL, {c[3:0], 4'h0});
         apb(1'b0, IDX_STATUS, 8'h00);
         chk(backplane_ref_src, e);
         chk(reference_clock_pin_oe_n, c != 8);
         chk(rd_q[2:0], {c < 4, c > 9 || (c > 3 && c < 8), c == 8});
         if (c < 4) chk(backplane_ref_port, c[1:0]);
      end
      $display("t_ref done");
   endtask
   task automatic t_master;
      for (int v = 0; v < 16; v++) begin
         apb(1'b1, IDX_CLK_REF_SEL, {4'h0, v[3:0]});
         apb(1'b1, IDX_FRAMER_CTRL, {2'h0, v[1:0], 4'h0});
         apb(1'b0, IDX_STATUS, 8'h00);
         chk(rd_q[31:16], (v[2] ? 16'h0608 : 16'h0800) << v[1:0]);
         chk({backplane_freq_sel, master_family_sel, master_period_sel}, v);
         chk(backplane_out_sel, v[1:0]);
      end
      $display("t_master done");
   endtask
   task automatic t_sys;
      backplane_clock <= 1'b1;
      {rx_system_clock_pin, tx_system_clock_pin} <= 8'h5a;
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, IDX_SYSCLK_SEL, {1'b0, m[1:0], 5'h00});
         repeat (5) @(posedge ref_clk);
         for (int i = 0; i < 4; i++) begin
            chk(port_out[i].rx_system_clock, m[1] | rx_system_clock_pin[i]);
            chk(port_out[i].tx_system_clock, m[0] | tx_system_clock_pin[i]);
         end
      end
      $display("t_sys done");
   endtask
   task automatic close_out;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // watchdog well past the expected run
   initial begin
      repeat (20000) @(posedge ref_clk);
      fails++;
      close_out();
   end
   initial begin
      repeat (10) @(posedge ref_clk);
      resetn <= 1'b1;
      t_pins();
      t_ref();
      t_master();
      t_sys();
      resetn <= 1'b0;
      repeat (3) @(posedge ref_clk);
      resetn <= 1'b1;
      t_regs();
      close_out();
   end
endmodule
`default_nettype wire
